// [hw/audio_serial_channel_pair.sv]
// Purpose: one i2s / dsp channel pair, slave or ws-synchronised master
// Assumes: register port on the block clock; sck, ws and sd from pins
// Notes:   sck is sampled unless master; bit rate must stay well below clock / 6
`timescale 1ns/1ns
`default_nettype none
`include "audio_serial_defines.svh"

module audio_serial_channel_pair
  import audio_serial_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic                   clock,     // block clock, 100 MHz
  input  wire logic                   rst,       // synchronous reset, active high
  input  wire logic                   ce,        // clock enable, freezes all state
  input  wire logic [`AS_ADDR_W-1:0]  addr,      // register byte address
  input  wire logic [`AS_WORD_W-1:0]  wdata,     // register write data
  input  wire logic                   wr,        // write strobe
  input  wire logic                   rd,        // read strobe
  output logic      [`AS_WORD_W-1:0]  rdata,     // read data, cycle after rd
  output logic                        irq,       // level interrupt
  input  wire logic                   sck_in,    // bit clock pin level
  output logic                        sck_out,   // bit clock drive value
  output logic                        sck_oe_n,  // bit clock enable, low drives
  input  wire logic                   ws_in,     // word select pin
  input  wire logic                   sd_in,     // serial data in pin
  output logic                        sd_out     // serial data out pin
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div
    $error("audio_serial_channel_pair: DIV_W must be 2..16");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                   en_q;        // enable
  logic                   dsp_q;       // 0 i2s, 1 dsp framing
  logic [1:0]             sel_q;       // master_slave_select
  logic [4:0]             len_q;       // word_length_field
  logic [DIV_W-1:0]       div_q;       // bit clock half period minus one
  logic [`AS_EV_W-1:0]    mask_q;      // interrupt mask
  logic [`AS_EV_W-1:0]    status_q;    // sticky events
  logic [`AS_WORD_W-1:0]  rdata_q;     // read data
  logic                   sck_s;       // synchronised pins
  logic                   ws_s;
  logic                   sd_s;
  logic                   sck_prev_q;  // last synced sck
  logic [DIV_W-1:0]       div_cnt_q;   // bit clock divider
  logic                   sck_gen_q;   // generated bit clock
  logic                   ws_prev_q;   // ws at previous sampling edge
  logic                   ws_seen_q;   // ws sampled since enable
  link_state_type         state_q;     // link state
  link_state_type         state_d;
  logic [`AS_CNT_W-1:0]   cnt_q;       // bits received in word
  logic [`AS_WORD_W-1:0]  shift_q;     // receive shifter
  logic                   chan_q;      // 0 left, 1 right
  logic                   msb_q;       // first bit of word
  logic [`AS_WORD_W-1:0]  rx_data_q;   // last complete word
  logic                   rx_right_q;  // its channel
  logic                   rx_valid_q;  // unread word
  logic [`AS_WORD_W-1:0]  tx_hold_q;   // software transmit word
  logic                   tx_full_q;   // hold occupied
  logic [`AS_WORD_W-1:0]  tx_word_q;   // word on the wire
  logic [`AS_CNT_W-1:0]   tx_left_q;   // bits still to send
  logic                   sd_out_q;    // data pin register
  logic [`AS_WORD_W-1:0]  cfg_view;    // read views
  logic [`AS_WORD_W-1:0]  stat_view;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire sel_cfg  = (addr == `AS_CFG_ADDR);
  wire sel_div  = (addr == `AS_DIV_ADDR);
  wire sel_stat = (addr == `AS_STAT_ADDR);
  wire sel_mask = (addr == `AS_MASK_ADDR);
  wire sel_tx   = (addr == `AS_TX_ADDR);
  wire sel_rx   = (addr == `AS_RX_ADDR);
  wire wr_cfg   = wr && sel_cfg;
  wire wr_div   = wr && sel_div;
  wire wr_mask  = wr && sel_mask;
  wire wr_tx    = wr && sel_tx;
  wire rd_stat  = rd && sel_stat;
  wire rd_rx    = rd && sel_rx;

  // word length: field plus one, shared by both directions
  wire [`AS_CNT_W-1:0] word_len = {1'b0, len_q} + `AS_CNT_ONE;
  // both select values keep ws an input; 0x1 also drives sck
  wire master = en_q && (sel_q == `AS_SEL_WS_MASTER);
  wire run    = (state_q == ST_RUN);

  // configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      en_q   <= 1'b0;
      dsp_q  <= 1'b0;
      sel_q  <= `AS_SEL_SLAVE;
      len_q  <= `AS_LEN_RESET;
      div_q  <= DIV_W'(`AS_DIV_RESET);
      mask_q <= '0;
    end else if (ce) begin
      if (wr_cfg) begin
        en_q  <= wdata[`AS_CFG_EN];
        dsp_q <= wdata[`AS_CFG_DSP];
        sel_q <= wdata[`AS_CFG_SEL_MSB:`AS_CFG_SEL_LSB];
        len_q <= wdata[`AS_CFG_LEN_MSB:`AS_CFG_LEN_LSB];
      end
      if (wr_div)  div_q  <= wdata[DIV_W-1:0];
      if (wr_mask) mask_q <= wdata[`AS_EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  bit_synchroniser #(
    .WIDTH    (3)
  ) u_pin_sync (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .async_in ({sck_in, ws_in, sd_in}),
    .sync_out ({sck_s, ws_s, sd_s})
  );

  // ----------------------------------------------------------------
  // bit clock: generated in master mode, sampled otherwise
  // ----------------------------------------------------------------
  wire tick = master && (div_cnt_q == div_q);

  // divider, held at zero while not master
  always_ff @(posedge clock) begin
    if (rst) begin
      div_cnt_q  <= '0;
      sck_gen_q  <= 1'b0;
      sck_prev_q <= 1'b0;
    end else if (ce) begin
      sck_prev_q <= sck_s;
      if (!master) begin
        div_cnt_q <= '0;
        sck_gen_q <= 1'b0;
      end else if (tick) begin
        div_cnt_q <= '0;
        sck_gen_q <= ~sck_gen_q;
      end else begin
        div_cnt_q <= div_cnt_q + 1'b1;
      end
    end
  end

  assign sck_out  = sck_gen_q;
  assign sck_oe_n = ~master;

  // sampling edge and shifting edge of the bit clock
  wire rise = master ? (tick && !sck_gen_q) : (sck_s && !sck_prev_q);
  wire fall = master ? (tick && sck_gen_q)  : (!sck_s && sck_prev_q);

  // ----------------------------------------------------------------
  // word select sampling and frame start detection
  // ----------------------------------------------------------------
  // an edge counts only between two samples taken after enable
  always_ff @(posedge clock) begin
    if (rst) begin
      ws_prev_q <= 1'b0;
      ws_seen_q <= 1'b0;
    end else if (ce) begin
      if (!en_q) begin
        ws_seen_q <= 1'b0;
      end else if (rise) begin
        ws_prev_q <= ws_s;
        ws_seen_q <= 1'b1;
      end
    end
  end

  wire ws_rise_e = rise && ws_seen_q && ws_s && !ws_prev_q;
  wire ws_fall_e = rise && ws_seen_q && !ws_s && ws_prev_q;
  // frame start: i2s on falling ws, dsp on rising ws
  wire lock_edge = dsp_q ? ws_rise_e : ws_fall_e;
  wire lock_ev   = (state_q == ST_HUNT) && en_q && lock_edge;

  // link state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (en_q) state_d = ST_HUNT;
      ST_HUNT: begin
        if (!en_q)          state_d = ST_IDLE;
        else if (lock_edge) state_d = ST_RUN;
      end
      ST_RUN:  if (!en_q) state_d = ST_IDLE;
      default: state_d = ST_IDLE;  // illegal code
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) state_q <= ST_IDLE;
    else if (ce) state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  wire                  rx_live    = run && rise && (cnt_q < word_len);
  wire                  rx_done    = rx_live && ((cnt_q + `AS_CNT_ONE) == word_len);
  wire [`AS_WORD_W-1:0] shift_next = {shift_q[`AS_WORD_W-2:0], sd_s};
  // dsp: right word follows the left one directly; i2s: every ws edge
  wire word_start = lock_ev ||
                    (run && en_q && (dsp_q ? (ws_rise_e || (rx_done && !chan_q))
                                           : (ws_rise_e || ws_fall_e)));
  wire chan_next  = dsp_q ? !ws_rise_e : ws_s;

  // shifter and bit count; the bit at a word-start edge ends the old word
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q   <= '0;
      shift_q <= '0;
      chan_q  <= 1'b0;
      msb_q   <= 1'b0;
    end else if (ce) begin
      if (rx_live && (cnt_q == '0)) msb_q <= sd_s;
      if (word_start) begin
        cnt_q   <= '0;
        shift_q <= '0;
        chan_q  <= chan_next;
      end else if (rx_live) begin
        cnt_q   <= cnt_q + `AS_CNT_ONE;
        shift_q <= shift_next;
      end
    end
  end

  // completed word, all configured bits kept right aligned
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_data_q  <= '0;
      rx_right_q <= 1'b0;
      rx_valid_q <= 1'b0;
    end else if (ce) begin
      if (rx_done) begin
        rx_data_q  <= shift_next;
        rx_right_q <= chan_q;
      end
      rx_valid_q <= rx_done | (rx_valid_q & ~rd_rx);
    end
  end

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  wire                 underrun_ev = word_start && !tx_full_q;
  wire                 tx_shift    = run && fall && (tx_left_q != '0);
  wire [4:0]           tx_bit      = 5'(tx_left_q - `AS_CNT_ONE);

  // holding word; a write in the consuming cycle keeps it full
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_hold_q <= '0;
      tx_full_q <= 1'b0;
    end else if (ce) begin
      if (wr_tx) tx_hold_q <= wdata;
      tx_full_q <= wr_tx | (tx_full_q & ~word_start);
    end
  end

  // msb first, changed on the falling edge; zeros on underrun
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_word_q <= '0;
      tx_left_q <= '0;
      sd_out_q  <= 1'b0;
    end else if (ce) begin
      if (!en_q) begin
        tx_left_q <= '0;
        sd_out_q  <= 1'b0;
      end else if (word_start) begin
        tx_word_q <= tx_full_q ? tx_hold_q : '0;
        tx_left_q <= word_len;
      end else if (tx_shift) begin
        sd_out_q  <= tx_word_q[tx_bit];
        tx_left_q <= tx_left_q - `AS_CNT_ONE;
      end else if (fall) begin
        sd_out_q  <= 1'b0;
      end
    end
  end

  assign sd_out = sd_out_q;

  // ----------------------------------------------------------------
  // status, interrupt and read data
  // ----------------------------------------------------------------
  wire [`AS_EV_W-1:0] events = {lock_ev, rx_done && rx_valid_q && !rd_rx, rx_done, underrun_ev};

  // sticky bits, cleared by a read, a new event wins
  always_ff @(posedge clock) begin
    if (rst) status_q <= '0;
    else if (ce) status_q <= events | (status_q & ~{`AS_EV_W{rd_stat}});
  end

  assign irq = |(status_q & mask_q);

  // read views
  always_comb begin
    cfg_view = '0;
    cfg_view[`AS_CFG_EN]  = en_q;
    cfg_view[`AS_CFG_DSP] = dsp_q;
    cfg_view[`AS_CFG_SEL_MSB:`AS_CFG_SEL_LSB] = sel_q;
    cfg_view[`AS_CFG_LEN_MSB:`AS_CFG_LEN_LSB] = len_q;
    stat_view = '0;
    stat_view[`AS_EV_W-1:0]    = status_q;
    stat_view[`AS_ST_TX_FULL]  = tx_full_q;
    stat_view[`AS_ST_RX_VALID] = rx_valid_q;
    stat_view[`AS_ST_RUN]      = run;
    stat_view[`AS_ST_RX_RIGHT] = rx_right_q;
  end

  wire [`AS_WORD_W-1:0] rd_value =
    sel_cfg  ? cfg_view :
    sel_div  ? `AS_WORD_W'(div_q) :
    sel_stat ? stat_view :
    sel_mask ? `AS_WORD_W'(mask_q) :
    sel_rx   ? rx_data_q : '0;

  // read data stands one cycle, zero otherwise
  always_ff @(posedge clock) begin
    if (rst) rdata_q <= '0;
    else if (ce) rdata_q <= rd ? rd_value : '0;
  end

  assign rdata = rdata_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_len_field;
    rx_done && ce |-> cnt_q == {1'b0, len_q};
  endproperty
  a_len_field: assert property (p_len_field) else $error("word ends off length");

  property p_tx_len;
    word_start && ce |=> tx_left_q == $past(word_len);
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("tx bit count wrong");

  property p_pair;
    rx_done && ce |=> (rx_right_q == $past(chan_q)) && rx_valid_q;
  endproperty
  a_pair: assert property (p_pair) else $error("rx channel tag wrong");

  property p_i2s_chan;
    word_start && ce && !dsp_q |=> chan_q == $past(ws_s);
  endproperty
  a_i2s_chan: assert property (p_i2s_chan) else $error("channel not from ws");

  property p_slave_quiet;
    en_q && (sel_q == `AS_SEL_SLAVE) |-> sck_oe_n && !tick;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives sck");

  property p_no_early_lock;
    (state_q == ST_HUNT) && !ws_seen_q && ce |=> state_q != ST_RUN;
  endproperty
  a_no_early_lock: assert property (p_no_early_lock) else $error("lock without history");

  property p_frame_edge;
    lock_ev && ce |-> (dsp_q ? (ws_s && !ws_prev_q) : (!ws_s && ws_prev_q)) ##1 run;
  endproperty
  a_frame_edge: assert property (p_frame_edge) else $error("lock on wrong ws edge");

  property p_underrun;
    underrun_ev && ce |=> status_q[`AS_EV_UNDERRUN] && tx_word_q == '0
                          && (irq || !mask_q[`AS_EV_UNDERRUN]);
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");

  property p_msb_kept;
    rx_done && ce && (len_q != '0) |=> rx_data_q[$past(len_q)] == $past(msb_q);
  endproperty
  a_msb_kept: assert property (p_msb_kept) else $error("received msb lost");

  c_lock:     cover property (lock_ev && ce);
  c_underrun: cover property (underrun_ev && ce);
  c_dsp_pair: cover property (rx_done && dsp_q && chan_q && ce);
  c_master:   cover property (rx_done && master && ce);

endmodule

`default_nettype wire

// [hw/audio_serial_defines.svh]
// Purpose: register map, field positions and reset values of the audio serial channel pair
// Assumes: included by bare name; definitions only
// Notes:   the package holds the types
//
// Notes on behaviour
// - word size equals length field plus one
// - one length setting sets tx and rx bits
// - one left/right channel pair per instance
// - ws marks frame start and channel
// - both select values take ws from outside
// - late enable locks to true frame start
// - i2s frames on ws fall, dsp on rise
// - empty transmit word flags underrun, raises interrupt
`ifndef AUDIO_SERIAL_DEFINES_SVH
`define AUDIO_SERIAL_DEFINES_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define AS_ADDR_W        8
`define AS_CFG_ADDR      8'h00
`define AS_DIV_ADDR      8'h04
`define AS_STAT_ADDR     8'h08
`define AS_MASK_ADDR     8'h0C
`define AS_TX_ADDR       8'h10
`define AS_RX_ADDR       8'h14

// ----------------------------------------------------------------
// primary_config_register fields
// ----------------------------------------------------------------
`define AS_CFG_EN        0
`define AS_CFG_DSP       1
`define AS_CFG_SEL_LSB   2
`define AS_CFG_SEL_MSB   3
`define AS_CFG_LEN_LSB   8
`define AS_CFG_LEN_MSB   12
`define AS_SEL_SLAVE     2'h0
`define AS_SEL_WS_MASTER 2'h1
`define AS_LEN_RESET     5'h0F
`define AS_DIV_RESET     8'h04

// ----------------------------------------------------------------
// fifo_status_register: sticky events and live state bits
// ----------------------------------------------------------------
`define AS_EV_W          4
`define AS_EV_UNDERRUN   0
`define AS_EV_RX_READY   1
`define AS_EV_OVERRUN    2
`define AS_EV_LOCK       3
`define AS_ST_TX_FULL    8
`define AS_ST_RX_VALID   9
`define AS_ST_RUN        10
`define AS_ST_RX_RIGHT   11

// ----------------------------------------------------------------
// data path sizes
// ----------------------------------------------------------------
`define AS_WORD_W        32
`define AS_CNT_W         6
`define AS_CNT_ONE       6'h01

`endif

// [hw/audio_serial_pkg.sv]
// Purpose: shared types of the audio serial channel pair
// Assumes: constants live in audio_serial_defines.svh
// Notes:   one-hot link state codes
package audio_serial_pkg;

  // ----------------------------------------------------------------
  // link state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,  // disabled
    ST_HUNT = 3'b010,  // enabled, waiting for a true frame start
    ST_RUN  = 3'b100   // locked, words moving
  } link_state_type;

endpackage

// [hw/bit_synchroniser.sv]
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: ce freezes the chain with the rest of the block
// Notes:   only the second stage is visible outside
`timescale 1ns/1ns
`default_nettype none

module bit_synchroniser #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,     // block clock
  input  wire logic             rst,       // synchronous reset, active high
  input  wire logic             ce,        // clock enable
  input  wire logic [WIDTH-1:0] async_in,  // raw pin levels
  output logic      [WIDTH-1:0] sync_out   // synchronised levels
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("bit_synchroniser: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_q;  // first stage, read only by second

  // two stages, both frozen by ce
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// [testbench/i2s_far_master.sv]
// Purpose: behavioural far-end audio bus master for the channel pair bench
// Assumes: own bit clock of 125 ns unless the block drives the line; 64 bit periods a frame
// Notes:   i2s uses 32-bit slots; dsp packs left then right after a one-bit ws pulse
`timescale 1ns/1ns
`default_nettype none

module i2s_far_master (
  input  wire logic        run,      // frames flow while high
  input  wire logic        dsp,      // dsp framing instead of i2s
  input  wire logic [5:0]  nbits,    // bits in a word
  input  wire logic [31:0] left_w,   // left word to send
  input  wire logic [31:0] right_w,  // right word to send
  input  wire logic        sck,      // resolved bit clock line
  output logic             sck_drv,  // own bit clock drive
  output logic             ws,       // word select
  output logic             sd,       // data toward the block
  input  wire logic        sd_rx,    // data from the block
  output logic             idle,     // no frame in progress
  output logic [31:0]      got_l,    // last left word caught
  output logic [31:0]      got_r     // last right word caught
);
  int          j;   // bit position in the frame
  int          q;   // bit position in the word
  int          nb;  // word length
  logic        ch;  // right channel
  logic [31:0] sh;  // capture shifter

  // ------------------------------------------------------------
  // own bit clock, still between frames, phase off the block clock
  // ------------------------------------------------------------
  initial begin
    sck_drv = 1'b1;
    #1;
    forever begin
      #62;
      if (!idle) sck_drv = 1'b0;
      #63;
      sck_drv = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // frames: ws and data change on falls, block data caught on rises
  // ------------------------------------------------------------
  initial begin
    ws = 1'b1;
    sd = 1'b0;
    idle = 1'b1;
    sh = 32'h0000_0000;
    got_l = 32'h0000_0000;
    got_r = 32'h0000_0000;
    forever begin
      wait (run);
      idle = 1'b0;
      nb = int'(nbits);
      for (int k = 0; k < 64; k++) begin
        @(negedge sck);
        j = (k + 63) % 64;
        if (k == 0) ws = dsp;               // i2s falls, dsp rises
        if (k == 1 && dsp) ws = 1'b0;
        if (k == 32 && !dsp) ws = 1'b1;     // right channel
        ch = dsp ? (j >= nb) : (j >= 32);
        q = dsp ? (ch ? j - nb : j) : j % 32;
        sd = (q < nb) ? (ch ? right_w[nb-1-q] : left_w[nb-1-q]) : ~sd;
        @(posedge sck);
        if (q < nb) begin
          sh = (q == 0) ? {31'h0000_0000, sd_rx} : {sh[30:0], sd_rx};
          if (q == nb - 1 && ch) got_r = sh;
          if (q == nb - 1 && !ch) got_l = sh;
        end
      end
      if (!run) begin
        sd = ~sd;     // released line shows no stale bit
        idle = 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// [testbench/audio_serial_channel_pair_tb_top.sv]
// Purpose: self-checking bench of the audio serial channel pair
// Assumes: register port, far-end master model, ce tied high
// Notes:   one late-enable i2s slave run and one dsp ws-master run
`timescale 1ns/1ns
`default_nettype none
`include "audio_serial_defines.svh"

module audio_serial_channel_pair_tb_top;
  logic        clock, rst, wr, rd, irq;      // clock, reset, strobes, interrupt
  logic [7:0]  addr;                         // register address
  logic [31:0] wdata, rdata;                 // register data
  logic        sck_out, sck_oe_n, sck_drv;   // bit clock drives
  logic        sck_line, ws, sd_to, sd_out;  // bus lines
  logic        run, dsp, idle;               // far end control
  logic [5:0]  nbits;                        // far end word length
  logic [31:0] left_w, right_w, got_l, got_r; // far end words
  int          fails;                        // mismatches
  int          check_count;                  // comparisons

  assign sck_line = sck_oe_n ? sck_drv : sck_out;  // whoever is enabled owns sck

  audio_serial_channel_pair #(.DIV_W(8)) dut (
    .clock(clock), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .sck_in(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .ws_in(ws), .sd_in(sd_to), .sd_out(sd_out));

  i2s_far_master far (
    .run(run), .dsp(dsp), .nbits(nbits), .left_w(left_w), .right_w(right_w),
    .sck(sck_line), .sck_drv(sck_drv), .ws(ws), .sd(sd_to), .sd_rx(sd_out),
    .idle(idle), .got_l(got_l), .got_r(got_r));

  always #5 clock = ~clock;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;  // data stands only in this cycle
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // reset values, unmapped place ignored and read as zero
  // ------------------------------------------------------------
  task automatic test_reset();
    logic [31:0] d;
    logic [7:0]  a [5] = '{`AS_CFG_ADDR, `AS_DIV_ADDR, `AS_STAT_ADDR, `AS_MASK_ADDR, 8'h20};
    logic [31:0] e [5] = '{32'h0000_0F00, 32'h0000_0004, 32'h0000_0000, 32'h0000_0000,
                           32'h0000_0000};
    reg_wr(8'h20, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++) begin
      reg_rd(a[i], d);
      check(d, e[i]);
    end
    check({irq, sck_oe_n, sd_out}, 3'h2);
    $display("reset test done");
  endtask

  // ------------------------------------------------------------
  // one mode: lock, one word each way, underrun, status and irq
  // ------------------------------------------------------------
  task automatic run_mode(input logic dsp_m, input logic [1:0] sel, input logic [4:0] len,
                          input logic [3:0] msk, input logic late);
    logic [31:0] d, mask, tl, tr;
    mask = 32'hFFFF_FFFF >> (5'd31 - len);  // length field plus one bits
    dsp <= dsp_m;
    nbits <= {1'b0, len} + 6'h01;
    left_w <= 32'hA5C3_0F96;
    right_w <= 32'h9F37_79B9;
    reg_wr(`AS_MASK_ADDR, {28'h000_0000, msk});
    reg_wr(`AS_TX_ADDR, 32'hC35A_96F1);
    if (late) begin
      run <= 1'b1;
      @(negedge ws);  // bus running, frame just started
    end
    reg_wr(`AS_CFG_ADDR, {19'h0_0000, len, 4'h0, sel, dsp_m, 1'b1});
    run <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      if (dsp_m) @(posedge ws);
      else @(negedge ws);
    end
    repeat (2) @(posedge sck_line);
    tl = got_l;
    tr = got_r;
    run <= 1'b0;
    check(sck_oe_n, sel != 2'h1);
    check(tl, 32'hC35A_96F1 & mask);
    check(tr, 32'h0000_0000);
    check(irq, |msk);
    reg_rd(`AS_STAT_ADDR, d);
    check(d, 32'h0000_0E0F);
    check(irq, 1'b0);
    reg_rd(`AS_RX_ADDR, d);
    check(d, 32'h9F37_79B9 & mask);
    reg_rd(`AS_STAT_ADDR, d);
    check(d, 32'h0000_0C00);
    wait (idle);
    reg_wr(`AS_CFG_ADDR, 32'h0000_0000);
    $display("mode test done, dsp %0d select %0d", dsp_m, sel);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    run = 1'b0;
    dsp = 1'b0;
    nbits = 6'h10;
    left_w = 32'h0000_0000;
    right_w = 32'h0000_0000;
    fails = 0;
    check_count = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    run_mode(1'b0, 2'h0, 5'h1F, 4'h0, 1'b1);  // i2s slave, 32-bit, late enable
    run_mode(1'b1, 2'h1, 5'h18, 4'h1, 1'b0);  // dsp ws master, 25-bit
    final_report();
  end

  initial begin
    #200_000;
    fails++;
    final_report();
  end
endmodule

`default_nettype wire
